/* src/cls_decode.sv */
// Decoder and address generator for compressed load/store formats.
// Assumes an async-read register file and a memory with fixed latency.
//
// Contract
// - PC-relative load adds unsigned offset up to 1020 bytes, loads word.
// - PC base is instruction address plus 4 with bit 1 cleared.
// - Eight-bit word count field shifted left two gives byte offset.
// - Register offset: base plus offset register, low regs, no write-back.
// - Byte store writes only low byte; word store writes whole register.
// - Sign-extend group: half store, half load, signed byte, signed half.
// - Halfword store writes source bits 0-15.
// - Register-offset halfword load clears destination bits 16-31.
// - Signed byte load copies bit 7 into bits 8-31.
// - Signed halfword load copies bit 15 into bits 16-31.
// - Immediate offset adds five-bit field; unscaled for byte accesses.
// - Word immediate offset is field times four.
// - Halfword immediate offset is field times two.
// - Immediate halfword load clears destination bits 16-31.
// - Each transfer takes the same fixed cycles as its full-width twin.
`timescale 1ns/1ps
`default_nettype none
module cls_decode (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        instr_valid,
    output var  logic        instr_ready,
    input  wire logic [15:0] instr,
    input  wire logic [31:0] instr_addr,
    output var  logic [2:0]  rf_base_sel,
    output var  logic [2:0]  rf_offset_sel,
    output var  logic [2:0]  rf_src_sel,
    input  wire logic [31:0] rf_base_data,
    input  wire logic [31:0] rf_offset_data,
    input  wire logic [31:0] rf_src_data,
    output var  logic        rf_we,
    output var  logic [2:0]  rf_waddr,
    output var  logic [31:0] rf_wdata,
    output var  logic        mem_req,
    output var  logic        mem_we,
    output var  logic [1:0]  mem_size,
    output var  logic [3:0]  mem_be,
    output var  logic [31:0] mem_addr,
    output var  logic [31:0] mem_wdata,
    input  wire logic [31:0] mem_rdata,
    output var  logic        done,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    cls_pkg::cls_state_t state_reg;
    cls_pkg::cls_state_t state_next;
    logic [15:0] instr_reg;
    logic [31:0] pc_reg;
    logic        enable_reg;
    logic        illegal_reg;
    logic [31:0] count_reg;
    logic [31:0] last_ea_reg;
    logic        signed_reg;
    logic [31:0] ext_data;
    // Format recognition on the incoming word
    wire in_pcrel = instr[15:11] == cls_pkg::OPC_PCREL;
    wire in_legal = in_pcrel
                  | (instr[15:12] == cls_pkg::OPC_REGOFF)
                  | (instr[15:13] == cls_pkg::OPC_IMMOFF)
                  | (instr[15:12] == cls_pkg::OPC_HALFIMM);
    wire take     = instr_valid & instr_ready;
    // Format recognition on the held word
    wire is_pcrel   = instr_reg[15:11] == cls_pkg::OPC_PCREL;
    wire is_regoff  = (instr_reg[15:12] == cls_pkg::OPC_REGOFF)
                    & ~instr_reg[cls_pkg::F_SEXT_SEL];
    wire is_sext    = (instr_reg[15:12] == cls_pkg::OPC_REGOFF)
                    & instr_reg[cls_pkg::F_SEXT_SEL];
    wire is_immoff  = instr_reg[15:13] == cls_pkg::OPC_IMMOFF;
    wire is_halfimm = instr_reg[15:12] == cls_pkg::OPC_HALFIMM;
    wire [7:0] word_count_field   = instr_reg[7:0];
    wire [4:0] short_offset_field = instr_reg[10:6];
    wire       sign_flag          = instr_reg[cls_pkg::F_SIGN];
    wire       half_flag          = instr_reg[cls_pkg::F_HALF];

    // Direction: only the half store in the sign-extend group writes
    wire load_w = is_pcrel
                | (is_sext & (sign_flag | half_flag))
                | (~is_sext & instr_reg[cls_pkg::F_LOAD]);
    wire [1:0] size_w = is_pcrel ? cls_pkg::SIZE_WORD :
        is_regoff ? (instr_reg[cls_pkg::F_BYTE_REG] ?
                     cls_pkg::SIZE_BYTE : cls_pkg::SIZE_WORD) :
        is_sext ? ((sign_flag & ~half_flag) ?
                   cls_pkg::SIZE_BYTE : cls_pkg::SIZE_HALF) :
        is_immoff ? (instr_reg[cls_pkg::F_BYTE_IMM] ?
                     cls_pkg::SIZE_BYTE : cls_pkg::SIZE_WORD) :
        cls_pkg::SIZE_HALF;
    wire signed_w = is_sext & sign_flag;

    // Base and offset of the effective address
    wire [31:0] pc_base = (pc_reg + cls_pkg::PC_AHEAD)
                        & cls_pkg::PC_ALIGN_MASK;
    wire [31:0] base_w = is_pcrel ? pc_base : rf_base_data;
    wire [31:0] offset_w =
        is_pcrel ? {22'h00_0000, word_count_field, 2'h0} :
        (is_regoff | is_sext) ? rf_offset_data :
        (is_immoff & instr_reg[cls_pkg::F_BYTE_IMM]) ?
            {27'h000_0000, short_offset_field} :
        is_immoff ? {25'h000_0000, short_offset_field, 2'h0} :
        {26'h000_0000, short_offset_field, 1'h0};
    wire [31:0] ea_w = base_w + offset_w;

    // Store lanes; narrow data is repeated so any lane carries it
    wire [31:0] wdata_w = (size_w == cls_pkg::SIZE_BYTE) ?
                              {4{rf_src_data[7:0]}} :
                          (size_w == cls_pkg::SIZE_HALF) ?
                              {2{rf_src_data[15:0]}} :
                          rf_src_data;
    wire [3:0]  be_w = (size_w == cls_pkg::SIZE_BYTE) ?
                           (4'h1 << ea_w[1:0]) :
                       (size_w == cls_pkg::SIZE_HALF) ?
                           (ea_w[1] ? 4'hC : 4'h3) :
                       4'hF;
    cls_load_extend u_extend (
        .size     (mem_size),
        .sign_ext (signed_reg),
        .lane     (mem_addr[1:0]),
        .rdata    (mem_rdata),
        .ext_data (ext_data)
    );

    // Fixed sequence: stores two cycles after taking, loads three
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cls_pkg::ST_IDLE: begin
                if (take && in_legal) begin
                    state_next = cls_pkg::ST_CALC;
                end
            end
            cls_pkg::ST_CALC: begin
                state_next = cls_pkg::ST_ACCESS;
            end
            cls_pkg::ST_ACCESS: begin
                state_next = load_w ? cls_pkg::ST_WBACK :
                                      cls_pkg::ST_IDLE;
            end
            default: begin
                state_next = cls_pkg::ST_IDLE;
            end
        endcase
    end
    wire st_calc   = state_reg == cls_pkg::ST_CALC;
    wire st_access = state_reg == cls_pkg::ST_ACCESS;
    wire st_wback  = state_reg == cls_pkg::ST_WBACK;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg   <= cls_pkg::ST_IDLE;
            instr_ready <= 1'b0;
            mem_req     <= 1'b0;
            rf_we       <= 1'b0;
            done        <= 1'b0;
        end else begin
            state_reg   <= state_next;
            instr_ready <= enable_reg & (state_next == cls_pkg::ST_IDLE);
            mem_req     <= st_calc;
            rf_we       <= st_wback;
            done        <= (st_access & ~load_w) | st_wback;
        end
    end

    // Capture on take; register selects drive the file for the next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            instr_reg     <= 16'h0000;
            pc_reg        <= 32'h0000_0000;
            rf_base_sel   <= 3'h0;
            rf_offset_sel <= 3'h0;
            rf_src_sel    <= 3'h0;
            rf_waddr      <= 3'h0;
        end else if (take && in_legal) begin
            instr_reg     <= instr;
            pc_reg        <= instr_addr;
            rf_base_sel   <= instr[cls_pkg::F_BASE_LSB +: 3];
            rf_offset_sel <= instr[cls_pkg::F_OFF_LSB +: 3];
            rf_src_sel    <= in_pcrel ? instr[cls_pkg::F_PC_RD_LSB +: 3] :
                                        instr[cls_pkg::F_RD_LSB +: 3];
            rf_waddr      <= in_pcrel ? instr[cls_pkg::F_PC_RD_LSB +: 3] :
                                        instr[cls_pkg::F_RD_LSB +: 3];
        end
    end

    // Memory request fields; base register is never written back
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_we      <= 1'b0;
            mem_size    <= cls_pkg::SIZE_WORD;
            mem_be      <= 4'h0;
            mem_addr    <= 32'h0000_0000;
            mem_wdata   <= 32'h0000_0000;
            signed_reg  <= 1'b0;
            last_ea_reg <= 32'h0000_0000;
        end else if (st_calc) begin
            mem_we      <= ~load_w;
            mem_size    <= size_w;
            mem_be      <= be_w;
            mem_addr    <= ea_w;
            mem_wdata   <= wdata_w;
            signed_reg  <= signed_w;
            last_ea_reg <= ea_w;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rf_wdata <= 32'h0000_0000;
        end else if (st_wback) begin
            rf_wdata <= ext_data;
        end
    end

    // Register slave: one write and one read in flight
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    wire aw_fire   = s_axi_awvalid & s_axi_awready;
    wire w_fire    = s_axi_wvalid & s_axi_wready;
    wire wr_do     = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire ar_fire   = s_axi_arvalid & s_axi_arready;
    wire wr_ctrl   = awaddr_reg[7:2] == cls_pkg::REG_CTRL[7:2];
    wire wr_status = awaddr_reg[7:2] == cls_pkg::REG_STATUS[7:2];
    wire wr_hit    = wr_ctrl | wr_status;
    wire rd_ctrl   = s_axi_araddr[7:2] == cls_pkg::REG_CTRL[7:2];
    wire rd_status = s_axi_araddr[7:2] == cls_pkg::REG_STATUS[7:2];
    wire rd_count  = s_axi_araddr[7:2] == cls_pkg::REG_COUNT[7:2];
    wire rd_ea     = s_axi_araddr[7:2] == cls_pkg::REG_LAST_EA[7:2];
    wire [31:0] status_w = {30'h0000_0000, illegal_reg,
                            state_reg != cls_pkg::ST_IDLE};
    wire [31:0] rd_mux = rd_ctrl   ? {31'h0000_0000, enable_reg} :
                         rd_status ? status_w :
                         rd_count  ? count_reg :
                         rd_ea     ? last_ea_reg : 32'h0000_0000;
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cls_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_fire & ~aw_held_reg & ~s_axi_bvalid;
            s_axi_wready  <= ~w_fire & ~w_held_reg & ~s_axi_bvalid;
            if (aw_fire) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? cls_pkg::RESP_OKAY :
                                         cls_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= cls_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~ar_fire & ~s_axi_rvalid;
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (rd_ctrl | rd_status | rd_count | rd_ea) ?
                                cls_pkg::RESP_OKAY : cls_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Illegal flag: a new event wins over a software clear
    wire ill_set = take & ~in_legal;
    wire ill_clr = wr_do & wr_status & wstrb_reg[0]
                 & wdata_reg[cls_pkg::STAT_ILL_BIT];
    always_ff @(posedge clk) begin
        if (rst) begin
            enable_reg  <= cls_pkg::CTRL_EN_RST;
            illegal_reg <= 1'b0;
            count_reg   <= 32'h0000_0000;
        end else begin
            if (wr_do && wr_ctrl && wstrb_reg[0]) begin
                enable_reg <= wdata_reg[cls_pkg::CTRL_EN_BIT];
            end
            illegal_reg <= ill_set | (illegal_reg & ~ill_clr);
            if ((st_access && !load_w) || st_wback) begin
                count_reg <= count_reg + 32'h0000_0001;
            end
        end
    end

endmodule : cls_decode
`default_nettype wire

/* src/cls_pkg.sv */
// Shared constants for the compact load/store decoder.
// Assumes a 32-bit core with a little-endian data memory port.
package cls_pkg;

    // Register map, byte addresses on the AXI4-Lite slave
    localparam int          AXI_AW        = 8;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_COUNT     = 8'h08;
    localparam logic [7:0]  REG_LAST_EA   = 8'h0C;
    localparam int          CTRL_EN_BIT   = 0;
    localparam logic        CTRL_EN_RST   = 1'b1;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_ILL_BIT  = 1;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Opcode patterns of the five formats
    localparam logic [4:0]  OPC_PCREL     = 5'h09;
    localparam logic [3:0]  OPC_REGOFF    = 4'h5;
    localparam logic [2:0]  OPC_IMMOFF    = 3'h3;
    localparam logic [3:0]  OPC_HALFIMM   = 4'h8;

    // Field positions
    localparam int          F_SEXT_SEL    = 9;
    localparam int          F_LOAD        = 11;
    localparam int          F_BYTE_REG    = 10;
    localparam int          F_BYTE_IMM    = 12;
    localparam int          F_SIGN        = 10;
    localparam int          F_HALF        = 11;
    localparam int          F_PC_RD_LSB   = 8;
    localparam int          F_OFF_LSB     = 6;
    localparam int          F_BASE_LSB    = 3;
    localparam int          F_RD_LSB      = 0;

    // Program counter adjust and alignment
    localparam logic [31:0] PC_AHEAD      = 32'h0000_0004;
    localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFF_FFFD;

    // Transfer sizes
    localparam logic [1:0]  SIZE_BYTE     = 2'h0;
    localparam logic [1:0]  SIZE_HALF     = 2'h1;
    localparam logic [1:0]  SIZE_WORD     = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_CALC   = 2'b01,
        ST_ACCESS = 2'b10,
        ST_WBACK  = 2'b11
    } cls_state_t;

endpackage : cls_pkg

/* src/cls_load_extend.sv */
// Lane selection and extension of loaded data into a register value.
// Assumes the memory returns the whole aligned word, little endian.
`timescale 1ns/1ps
`default_nettype none
module cls_load_extend (
    input  wire logic [1:0]  size,
    input  wire logic        sign_ext,
    input  wire logic [1:0]  lane,
    input  wire logic [31:0] rdata,
    output var  logic [31:0] ext_data
);
    logic [7:0]  byte_sel;
    logic [15:0] half_sel;

    assign byte_sel = (lane == 2'h0) ? rdata[7:0]   :
                      (lane == 2'h1) ? rdata[15:8]  :
                      (lane == 2'h2) ? rdata[23:16] : rdata[31:24];
    assign half_sel = lane[1] ? rdata[31:16] : rdata[15:0];

    always_comb begin
        ext_data = rdata;
        if (size == cls_pkg::SIZE_BYTE) begin
            if (sign_ext) begin
                ext_data = {{24{byte_sel[7]}}, byte_sel};
            end else begin
                ext_data = {24'h00_0000, byte_sel};
            end
        end else if (size == cls_pkg::SIZE_HALF) begin
            if (sign_ext) begin
                ext_data = {{16{half_sel[15]}}, half_sel};
            end else begin
                ext_data = {16'h0000, half_sel};
            end
        end
    end
endmodule : cls_load_extend
`default_nettype wire

/* bench/cls_decode_checker.sv */
// Timing and address checks on the decoder.
// Assumes the bind below and the decoder's fixed latencies.
`timescale 1ns/1ps
`default_nettype none
module cls_decode_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        instr_valid,
    input wire logic        instr_ready,
    input wire logic [15:0] instr,
    input wire logic [31:0] instr_addr,
    input wire logic [31:0] rf_base_data,
    input wire logic [31:0] rf_offset_data,
    input wire logic [31:0] rf_src_data,
    input wire logic        rf_we,
    input wire logic [31:0] rf_wdata,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [1:0]  mem_size,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic        done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire       take  = instr_valid & instr_ready;
    wire       pcrel = instr[15:11] == 5'h09;
    wire       roff  = instr[15:12] == 4'h5;
    wire       imm   = instr[15:13] == 3'h3;
    wire       himm  = instr[15:12] == 4'h8;
    wire       ls    = pcrel | roff | imm | himm;
    wire       ld    = pcrel | (roff & (instr[11] | instr[9] & instr[10]))
                     | ((imm | himm) & instr[11]);
    wire [4:0] f     = instr[10:6];
    wire [6:0] ioff  = instr[12] ? {2'h0, f} : {f, 2'h0};
    sequence s_store;
        mem_req && mem_we ##1 done && !mem_req;
    endsequence
    sequence s_load;
        mem_req && !mem_we ##1 !mem_req ##1 done && rf_we;
    endsequence
    a_store_time: assert property (take && ls && !ld |-> ##2 s_store)
        else $error("store timing wrong");
    a_load_time: assert property (take && ld |-> ##2 s_load)
        else $error("load timing wrong");
    a_pc_rel_addr: assert property (take && pcrel |-> ##2 mem_addr ==
        (($past(instr_addr, 2) + 32'h4) & 32'hFFFF_FFFD)
        + {$past(instr[7:0], 2), 2'h0}) else $error("pc address wrong");
    a_reg_off_addr: assert property (take && roff |-> ##2 mem_addr ==
        $past(rf_base_data) + $past(rf_offset_data))
        else $error("register offset address wrong");
    a_imm_addr: assert property (take && imm |-> ##2 mem_addr ==
        $past(rf_base_data) + $past(ioff, 2)) else $error("imm address wrong");
    a_half_imm_addr: assert property (take && himm |-> ##2 mem_addr ==
        $past(rf_base_data) + {$past(f, 2), 1'b0})
        else $error("half address wrong");
    a_store_src: assert property (take && ls && !ld |-> ##2
        (mem_size == 2'h0 ? mem_wdata == {4{$past(rf_src_data[7:0])}}
        : mem_size == 2'h1 ? mem_wdata == {2{$past(rf_src_data[15:0])}}
        : mem_wdata == $past(rf_src_data))) else $error("store data wrong");
    a_load_lane: assert property (rf_we |-> (mem_size == 2'h2
        ? rf_wdata == $past(mem_rdata)
        : rf_wdata[7:0] == 8'($past(mem_rdata) >> {mem_addr[1:0], 3'h0})))
        else $error("load lane wrong");
endmodule : cls_decode_checker
bind cls_decode cls_decode_checker u_chk (.*);
`default_nettype wire

/* bench/cls_mem_model.sv */
// Data memory stand-in: answers a read one cycle after the request.
// Assumes the decoder's fixed-latency data port.
`timescale 1ns/1ps
`default_nettype none
module cls_mem_model (
    input  wire logic        clk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    output var  logic [31:0] mem_rdata
);
    logic        pend_reg;
    logic [31:0] word_reg;
    // Hashed contents, so nothing is stored
    always_ff @(posedge clk) begin
        pend_reg <= mem_req & ~mem_we;
        word_reg <= {mem_addr[31:2], 2'h0} * 32'h9E37_79B9;
    end
    // Junk outside the answer cycle, not the last word
    assign mem_rdata = pend_reg ? word_reg : ~word_reg;
endmodule : cls_mem_model
`default_nettype wire

/* bench/cls_decode_tb.sv */
// Self-checking bench for the decoder.
// Assumes cls_decode with the memory stand-in on its data port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module cls_decode_tb;
    typedef struct {
        logic we; logic [1:0] size; logic [31:0] addr;
        logic [3:0] be; logic [31:0] data; logic [2:0] rd;
    } cls_exp_t;
    typedef struct { logic [1:0] resp; logic [31:0] data; } cls_axe_t;
    logic        clk, rst, instr_valid, instr_ready, rf_we, done;
    logic        mem_req, mem_we, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] instr;
    logic [31:0] instr_addr, rf_base_data, rf_offset_data, rf_src_data;
    logic [31:0] rf_wdata, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] s_axi_wdata, s_axi_rdata, last_ea;
    logic [2:0]  rf_base_sel, rf_offset_sel, rf_src_sel, rf_waddr;
    logic [1:0]  mem_size, s_axi_bresp, s_axi_rresp;
    logic [3:0]  mem_be, s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] regs [8];
    cls_exp_t    eq[$];
    cls_axe_t    aq[$];
    cls_exp_t    e;
    cls_axe_t    a;
    int          n_errors, checks, ndone;
    cls_decode    dut (.*);
    cls_mem_model mem (.*);
    assign rf_base_data   = regs[rf_base_sel];
    assign rf_offset_data = regs[rf_offset_sel];
    assign rf_src_data    = regs[rf_src_sel];
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] mword(input logic [31:0] ad);
        return {ad[31:2], 2'h0} * 32'h9E37_79B9;
    endfunction : mword
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        if (done === 1'b1) begin
            if (eq.size() == 0) `CHK(done, 1'b0)
            else begin
                e = eq.pop_front();
                `CHK({mem_we, mem_size}, {e.we, e.size})
                `CHK(mem_addr, e.addr)
                `CHK(mem_be, e.be)
                if (e.we) `CHK(mem_wdata, e.data)
                else `CHK({rf_we, rf_waddr, rf_wdata}, {1'b1, e.rd, e.data})
            end
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            a = aq.pop_front();
            `CHK(s_axi_bresp, a.resp)
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            a = aq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, {a.resp, a.data})
        end
    end
    task automatic offer(input logic [15:0] i);
        int n;
        n = 0;
        instr <= i;
        instr_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (instr_ready !== 1'b1 && n < 100);
        instr_valid <= 1'b0;
        `CHK(n < 100, 1'b1)
    endtask : offer
    task automatic axw(input logic [7:0] ad, input logic [31:0] d,
                       input logic [1:0] r);
        int n;
        n = 0;
        aq.push_back('{r, 32'h0});
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [7:0] ad, input logic [31:0] d,
                       input logic [1:0] r);
        int n;
        n = 0;
        aq.push_back('{r, d});
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : axr
    // One random transfer of format k, variant s
    task automatic run_one(input int k, input logic [1:0] s);
        logic [15:0] i;
        logic [31:0] rv [8];
        logic [31:0] ia, w, src, msk;
        logic [2:0]  rb, ro;
        cls_exp_t    x;
        i = 16'($urandom);
        ia = $urandom & 32'hFFFF_FFFE;
        foreach (rv[r]) rv[r] = $urandom;
        rb = i[5:3];
        ro = i[8:6];
        x.rd = i[2:0];
        case (k)
            0: begin x.we = 0; x.size = 2; x.rd = i[10:8]; i = {5'h09, i[10:0]}; end
            1: begin x.we = ~s[1]; x.size = s[0] ? 0 : 2; i = {4'h5, s, 1'b0, i[8:0]}; end
            2: begin x.we = s == 0; x.size = s == 1 ? 0 : 1; i = {4'h5, s, 1'b1, i[8:0]}; end
            3: begin x.we = ~s[0]; x.size = s[1] ? 0 : 2; i = {3'h3, s, i[10:0]}; end
            default: begin x.we = ~s[0]; x.size = 1; i = {4'h8, s[0], i[10:0]}; end
        endcase
        // Aligned operands; misaligned words are undefined
        msk = x.size == 2 ? 32'h3 : {31'h0, x.size[0]};
        rv[rb] = rv[rb] & ~msk;
        rv[ro] = rv[ro] & ~msk;
        case (k)
            0: x.addr = ((ia + 32'h4) & 32'hFFFF_FFFD) + {i[7:0], 2'h0};
            1, 2: x.addr = rv[rb] + rv[ro];
            3: x.addr = rv[rb] + (s[1] ? {2'h0, i[10:6]} : {i[10:6], 2'h0});
            default: x.addr = rv[rb] + {i[10:6], 1'b0};
        endcase
        src = rv[x.rd];
        w = mword(x.addr) >> {x.addr[1:0], 3'h0};
        x.be = x.size == 2 ? 4'hF : (x.size == 1 ? 4'h3 : 4'h1) << x.addr[1:0];
        if (x.we) x.data = x.size == 2 ? src : x.size == 1 ? {2{src[15:0]}} : {4{src[7:0]}};
        else if (x.size == 2) x.data = mword(x.addr);
        else if (x.size == 1) x.data = {{16{w[15] & s[0] & k == 2}}, w[15:0]};
        else x.data = {{24{w[7] & s[0] & k == 2}}, w[7:0]};
        while (eq.size() != 0) @(posedge clk);
        @(posedge clk);
        foreach (rv[r]) regs[r] <= rv[r];
        instr_addr <= ia;
        eq.push_back(x);
        last_ea = x.addr;
        ndone++;
        offer(i);
    endtask : run_one
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = 16'h0;
        instr_addr = 32'h0;
        foreach (regs[r]) regs[r] = 32'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {n_errors, checks, ndone} = '0;
        void'($urandom(32'hDE54));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        axr(cls_pkg::REG_CTRL, 32'h1, cls_pkg::RESP_OKAY);
        repeat (3) begin
            for (int k = 0; k < 5; k++) begin
                for (int s = 0; s < 4; s++) run_one(k, 2'(s));
            end
        end
        while (eq.size() != 0) @(posedge clk);
        axr(cls_pkg::REG_COUNT, 32'(ndone), cls_pkg::RESP_OKAY);
        axr(cls_pkg::REG_LAST_EA, last_ea, cls_pkg::RESP_OKAY);
        axw(cls_pkg::REG_COUNT, 32'h5, cls_pkg::RESP_SLVERR);
        axr(8'h10, 32'h0, cls_pkg::RESP_SLVERR);
        offer(16'h0000);
        axr(cls_pkg::REG_STATUS, 32'h2, cls_pkg::RESP_OKAY);
        axw(cls_pkg::REG_STATUS, 32'h2, cls_pkg::RESP_OKAY);
        axr(cls_pkg::REG_STATUS, 32'h0, cls_pkg::RESP_OKAY);
        axw(cls_pkg::REG_CTRL, 32'h0, cls_pkg::RESP_OKAY);
        instr <= 16'h6000;
        instr_valid <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(instr_ready, 1'b0)
        instr_valid <= 1'b0;
        axw(cls_pkg::REG_CTRL, 32'h1, cls_pkg::RESP_OKAY);
        run_one(3, 2'h3);
        while (eq.size() != 0) @(posedge clk);
        `CHK(aq.size(), 0)
        print_verdict();
    end
    initial begin
        #(50 * 20000);
        n_errors++;
        print_verdict();
    end
endmodule : cls_decode_tb
`default_nettype wire
